//--- bench/adc_sequencer_control_tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_tb;
   logic        sys_clk;
   logic        rst_b;
   logic        hsel;
   logic        hwrite;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [7:1]  triggerIn;
   logic        globalIrqEnable;
   logic        interruptTaken;
   logic        irqReq;
   logic        convBusy;
   logic        convInit;
   logic [3:0]  chanPos;
   logic [3:0]  chanNeg;
   logic [1:0]  chanGain;
   logic        chanDiff;
   logic [1:0]  chanRef;
   logic [9:0]  convData;
   logic [9:0]  s;
   int          errors;
   int          n_checks;
   int          cycles;
   int          n;
   int          dv;

   adc_sequencer_control DUT (
      .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .convData(convData), .triggerIn(triggerIn), .globalIrqEnable(globalIrqEnable),
      .interruptTaken(interruptTaken), .irqReq(irqReq), .convBusy(convBusy),
      .convInit(convInit), .chanPos(chanPos), .chanNeg(chanNeg), .chanGain(chanGain),
      .chanDiff(chanDiff), .chanRef(chanRef)
   );
   analog_input_model analog (
      .sys_clk(sys_clk), .convBusy(convBusy), .chanPos(chanPos), .chanNeg(chanNeg),
      .chanDiff(chanDiff), .convData(convData)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // a hang ends the run well past the expected length
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         errors++;
         conclude();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // hready is looked at before the edge, so the edge itself is the sampling point
   task automatic waitRdy(output logic [7:0] d);
      do @(negedge sys_clk); while (hreadyout !== 1'b1);
      d = hrdata[7:0];
      @(posedge sys_clk);
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= adc_ctl_pkg::SIZE_WORD;
      waitRdy(rd);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      waitRdy(rd);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] x;
      bus(1'b0, a, 8'h00, x);
      chk({7'h00, hresp, x}, {8'h00, e});
   endtask

   task automatic waitConv();
      n = 0;
      while (convBusy !== 1'b0 && n < 5000)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 5000)
         errors++;
   endtask

   function automatic logic [10:0] chanExp(input logic [4:0] c);
      logic [3:0] p;
      logic [3:0] q;
      logic [1:0] g;
      p = {1'b0, c[2:0]};
      q = 4'h0;
      g = 2'h0;
      if (c[4:3] == 2'h1)
      begin
         p = {3'h0, c[0]} + {2'h0, c[2], 1'b0};
         q = {2'h0, c[2], 1'b0};
         g = c[1] ? 2'h2 : 2'h1;
      end
      else if (c[4])
         q = c[3] ? 4'h2 : 4'h1;
      if (c > 5'h1d)
      begin
         p = c[0] ? adc_ctl_pkg::IN_GROUND : adc_ctl_pkg::IN_BANDGAP;
         q = 4'h0;
      end
      return {p, q, g, (c[4] | c[3]) & (c < 5'h1e)};
   endfunction

   initial
   begin
      errors = 0;
      n_checks = 0;
      cycles = 0;
      rst_b = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      triggerIn = 7'h00;
      globalIrqEnable = 1'b0;
      interruptTaken = 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      // every register and one unmapped word read zero after reset
      for (int a = 0; a < 24; a += 4)
         rd(a[7:0], 8'h00);
      wr(adc_ctl_pkg::OFS_SELECT, 8'h03);
      wr(adc_ctl_pkg::OFS_CTRL, 8'hc0);
      chk({15'h0, convInit}, 16'h1);
      waitConv();
      chk({15'h0, n >= 49 && n <= 56}, 16'h1);
      // every divider code, 13 converter cycles each
      for (int p = 0; p < 8; p++)
      begin
         dv = (p < 2) ? 2 : (1 << p);
         wr(adc_ctl_pkg::OFS_CTRL, 8'hd0 | p[7:0]);
         chk({15'h0, convInit}, 16'h0);
         waitConv();
         // the free running prescaler adds up to one period before the first tick
         chk({15'h0, n >= 12 * dv + 3 && n <= 13 * dv + 3}, 16'h1);
         rd(adc_ctl_pkg::OFS_CTRL, 8'h90 | p[7:0]);
      end
      rd(adc_ctl_pkg::OFS_RES_LOW, 8'h61);
      rd(adc_ctl_pkg::OFS_RES_HIGH, 8'h00);
      // all input codes; a mid-conversion select change waits for the next start
      for (int c = 0; c < 32; c++)
      begin
         wr(adc_ctl_pkg::OFS_SELECT, c[7:0]);
         wr(adc_ctl_pkg::OFS_CTRL, 8'hd0);
         chk({5'h0, chanPos, chanNeg, chanGain, chanDiff}, {5'h0, chanExp(c[4:0])});
         wr(adc_ctl_pkg::OFS_SELECT, ~c[7:0] & 8'h1f);
         chk({5'h0, chanPos, chanNeg, chanGain, chanDiff}, {5'h0, chanExp(c[4:0])});
         waitConv();
         s = {1'b0, chanExp(c[4:0]) >> 3, 1'b1};
         rd(adc_ctl_pkg::OFS_RES_LOW, s[7:0]);
         rd(adc_ctl_pkg::OFS_RES_HIGH, {6'h0, s[9:8]});
      end
      wr(adc_ctl_pkg::OFS_SELECT, 8'h20);
      rd(adc_ctl_pkg::OFS_RES_HIGH, 8'h48);
      rd(adc_ctl_pkg::OFS_RES_LOW, 8'h40);
      wr(adc_ctl_pkg::OFS_SELECT, 8'h00);
      rd(adc_ctl_pkg::OFS_RES_LOW, 8'h21);
      // the low read locks the pair, so the next result is dropped
      wr(adc_ctl_pkg::OFS_SELECT, 8'hc5);
      wr(adc_ctl_pkg::OFS_CTRL, 8'hd0);
      chk({14'h0, chanRef}, 16'h3);
      waitConv();
      rd(adc_ctl_pkg::OFS_CTRL, 8'h90);
      rd(adc_ctl_pkg::OFS_RES_HIGH, 8'h01);
      rd(adc_ctl_pkg::OFS_RES_LOW, 8'h21);
      rd(adc_ctl_pkg::OFS_RES_HIGH, 8'h01);
      wr(adc_ctl_pkg::OFS_CTRL, 8'hd0);
      waitConv();
      rd(adc_ctl_pkg::OFS_RES_LOW, 8'ha1);
      rd(adc_ctl_pkg::OFS_RES_HIGH, 8'h00);
      // interrupt request: gated, cleared by the vector and by a written one
      wr(adc_ctl_pkg::OFS_CTRL, 8'h88);
      rd(adc_ctl_pkg::OFS_CTRL, 8'h98);
      chk({15'h0, irqReq}, 16'h0);
      globalIrqEnable <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk({15'h0, irqReq}, 16'h1);
      interruptTaken <= 1'b1;
      @(posedge sys_clk);
      interruptTaken <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({15'h0, irqReq}, 16'h0);
      rd(adc_ctl_pkg::OFS_CTRL, 8'h88);
      wr(adc_ctl_pkg::OFS_CTRL, 8'hc8);
      waitConv();
      repeat (2) @(posedge sys_clk);
      chk({15'h0, irqReq}, 16'h1);
      wr(adc_ctl_pkg::OFS_CTRL, 8'h98);
      rd(adc_ctl_pkg::OFS_CTRL, 8'h88);
      // abort, refused start, and a fresh 25-cycle start after re-enabling
      wr(adc_ctl_pkg::OFS_CTRL, 8'hc0);
      rd(adc_ctl_pkg::OFS_CTRL, 8'hc0);
      wr(adc_ctl_pkg::OFS_CTRL, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk({15'h0, convBusy}, 16'h0);
      rd(adc_ctl_pkg::OFS_CTRL, 8'h00);
      wr(adc_ctl_pkg::OFS_CTRL, 8'h40);
      chk({15'h0, convBusy}, 16'h0);
      wr(adc_ctl_pkg::OFS_CTRL, 8'hc0);
      chk({15'h0, convInit}, 16'h1);
      wr(adc_ctl_pkg::OFS_CTRL, 8'h80);
      chk({15'h0, convBusy}, 16'h1);
      waitConv();
      // one start per rising trigger edge, none from a steady level
      wr(adc_ctl_pkg::OFS_SPECIAL, 8'h20);
      wr(adc_ctl_pkg::OFS_CTRL, 8'hb0);
      chk({15'h0, convBusy}, 16'h0);
      triggerIn <= 7'h01;
      repeat (3) @(posedge sys_clk);
      chk({15'h0, convBusy}, 16'h1);
      waitConv();
      repeat (4) @(posedge sys_clk);
      chk({15'h0, convBusy}, 16'h0);
      triggerIn <= 7'h00;
      // free running: no start on switching, then restarts on completion
      wr(adc_ctl_pkg::OFS_SPECIAL, 8'h00);
      repeat (3) @(posedge sys_clk);
      chk({15'h0, convBusy}, 16'h0);
      // flag cleared in the same write, so a set flag proves one completion
      wr(adc_ctl_pkg::OFS_CTRL, 8'hf0);
      repeat (40) @(posedge sys_clk);
      chk({15'h0, convBusy}, 16'h1);
      rd(adc_ctl_pkg::OFS_CTRL, 8'hf0);
      wr(adc_ctl_pkg::OFS_CTRL, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire

//--- bench/analog_input_model.sv
// analog input model: returns a code built from the selected inputs
`timescale 1ns/1ps
`default_nettype none
module analog_input_model (
   input  wire logic       sys_clk,
   input  wire logic       convBusy,
   input  wire logic [3:0] chanPos,
   input  wire logic [3:0] chanNeg,
   input  wire logic       chanDiff,
   output var  logic [9:0] convData
);
   logic       heldBusy;
   logic [9:0] code;
   // offset binary
   // differential pairs come in offset binary, so the top bit follows chanDiff
   assign code = {chanDiff, chanPos, chanNeg, 1'b1};
   always_ff @(posedge sys_clk)
      heldBusy <= convBusy;
   // the lines show the code until one cycle after a conversion ends, then its inverse
   assign convData = (convBusy | heldBusy) ? code : ~code;
endmodule
`default_nettype wire

//--- logic/adc_ctl_pkg.sv
// shared constants and types of the converter control block
package adc_ctl_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_SELECT   = 8'h00;
   localparam logic [7:0] OFS_CTRL     = 8'h04;
   localparam logic [7:0] OFS_RES_LOW  = 8'h08;
   localparam logic [7:0] OFS_RES_HIGH = 8'h0c;
   localparam logic [7:0] OFS_SPECIAL  = 8'h10;

   // control/status field positions
   localparam int CTRL_ENABLE  = 7;
   localparam int CTRL_START   = 6;
   localparam int CTRL_AUTO    = 5;
   localparam int CTRL_FLAG    = 4;
   localparam int CTRL_IRQEN   = 3;
   localparam int CTRL_DIV_LSB = 0;

   // input select and special function field positions
   localparam int SEL_REF_LSB   = 6;
   localparam int SEL_ALIGN     = 5;
   localparam int SEL_MUX_LSB   = 0;
   localparam int SPEC_TRIG_LSB = 5;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] SIZE_WORD  = 3'h2;

   // conversion lengths in converter clock cycles
   localparam logic [4:0] FIRST_CYCLES  = 5'h19;
   localparam logic [4:0] NORMAL_CYCLES = 5'h0d;

   // prescaler codes at or below this one divide by two
   localparam logic [2:0] DIV_MIN_CODE = 3'h1;
   localparam logic [2:0] TRIG_FREE    = 3'h0;

   // analog input codes beyond the eight pins
   localparam logic [3:0] IN_BANDGAP = 4'h8;
   localparam logic [3:0] IN_GROUND  = 4'h9;
   localparam logic [1:0] GAIN_1X    = 2'h0;
   localparam logic [1:0] GAIN_10X   = 2'h1;
   localparam logic [1:0] GAIN_200X  = 2'h2;

   typedef struct packed {
      logic [3:0] pos;
      logic [3:0] neg;
      logic [1:0] gain;
      logic       diff;
   } chan_t;

   typedef enum logic {SEQ_IDLE, SEQ_CONVERT} seq_phase_t;

endpackage

//--- logic/adc_sequencer_control.sv
// register side, start control and result pair of the converter
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - five-bit input select; a change waits until the next conversion starts
// - codes 00000-00111 pick single-ended inputs zero to seven, no gain
// - 01xxx differential against input 0/2 at 10x/200x; 10xxx against input 1
// - 11000-11101 against input two; 11110 bandgap; 11111 ground
// - enable on switches converter on; off aborts any running conversion
// - start write begins one conversion, or the first of free running
// - first conversion after enabling takes 25 converter cycles, later 13
// - start bit reads one while converting; writing zero does nothing
// - with auto trigger, each rising edge of chosen trigger starts one unless one is running
// - completion flag sets when a conversion ends; results update unless the pair is frozen by a low byte read
// - interrupt request while flag, interrupt enable and global enable all set
// - flag clears when the vector is taken or software writes one
// - prescaler code divides system clock by 2,2,4,8,16,32,64,128
// - ten-bit result over two bytes; differential results in two's complement
// - reading low byte freezes result pair until the high byte is read
// - right aligned by default; left aligned puts bits 9:2 in high byte
// - alignment change reshapes the result view at once
// - differential results run 0x200 (-512) to 0x1ff (+511), msb is sign
// - trigger source zero is free running and makes no trigger edge
module adc_sequencer_control (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   input  wire logic [9:0]  convData,
   input  wire logic [7:1]  triggerIn,
   input  wire logic        globalIrqEnable,
   input  wire logic        interruptTaken,
   output var  logic        irqReq,
   output var  logic        convBusy,
   output var  logic        convInit,
   output var  logic [3:0]  chanPos,
   output var  logic [3:0]  chanNeg,
   output var  logic [1:0]  chanGain,
   output var  logic        chanDiff,
   output var  logic [1:0]  chanRef
);

   typedef struct packed {
      logic                enable;
      logic                active;
      logic                autoTrig;
      logic                flag;
      logic                irqEn;
      logic [2:0]          divSel;
      logic [1:0]          refSel;
      logic                align;
      logic [4:0]          inSel;
      logic [2:0]          trigSel;
      logic                firstPend;
      logic                firstNow;
      logic                startReq;
      logic                trigPrev;
      logic [9:0]          result;
      logic                lockLow;
      logic                dataPhase;
      logic                dWrite;
      logic                dValid;
      logic [7:0]          dAddr;
      logic [31:0]         rdata;
      logic                readyOut;
      logic                respErr;
      logic                irqReq;
      logic [1:0]          chanRef;
      adc_ctl_pkg::chan_t  chan;
   } ctl_state_t;

   ctl_state_t st;
   ctl_state_t next;
   logic       wrCtrl;
   logic       readHigh;
   logic       startWant;
   logic       trigLevel;
   logic [7:0] trigVec;
   logic [7:0] rdByte;

   conv_if cv ();

   conv_sequencer #(
      .PRE_W (7)
   ) u_seq (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .clkEn   (clkEn),
      .cv      (cv)
   );

   function automatic adc_ctl_pkg::chan_t decodeSel(input logic [4:0] sel);
      adc_ctl_pkg::chan_t c;
      c = '0;
      case (sel[4:3])
         2'b00:
            c.pos = {1'b0, sel[2:0]};
         2'b01:
         begin
            c.pos  = {2'b00, sel[2], sel[0]};
            c.neg  = {2'b00, sel[2], 1'b0};
            c.gain = sel[1] ? adc_ctl_pkg::GAIN_200X : adc_ctl_pkg::GAIN_10X;
            c.diff = 1'b1;
         end
         2'b10:
         begin
            c.pos  = {1'b0, sel[2:0]};
            c.neg  = 4'h1;
            c.diff = 1'b1;
         end
         default:
            if (sel[2:1] == 2'b11)
               c.pos = sel[0] ? adc_ctl_pkg::IN_GROUND : adc_ctl_pkg::IN_BANDGAP;
            else
            begin
               c.pos  = {1'b0, sel[2:0]};
               c.neg  = 4'h2;
               c.diff = 1'b1;
            end
      endcase
      return c;
   endfunction

   // alignment applied on the way out, not when stored
   function automatic logic [7:0] resultByte(input logic [9:0] r, input logic left,
                                             input logic high);
      if (high)
         return left ? r[9:2] : {6'h00, r[9:8]};
      return left ? {r[1:0], 6'h00} : r[7:0];
   endfunction

   always_comb
   begin
      next = st;
      next.startReq = 1'b0;
      wrCtrl = 1'b0;
      readHigh = 1'b0;
      startWant = 1'b0;
      rdByte = adc_ctl_pkg::RESET_BYTE;
      // data phase: one wait state, then the answer stands registered
      if (st.dataPhase)
      begin
         next.dataPhase = 1'b0;
         next.readyOut = 1'b1;
         if (st.dWrite && st.dValid)
         begin
            if (st.dAddr == adc_ctl_pkg::OFS_SELECT)
            begin
               next.refSel = hwdata[adc_ctl_pkg::SEL_REF_LSB +: 2];
               next.align = hwdata[adc_ctl_pkg::SEL_ALIGN];
               next.inSel = hwdata[adc_ctl_pkg::SEL_MUX_LSB +: 5];
            end
            else if (st.dAddr == adc_ctl_pkg::OFS_CTRL)
               wrCtrl = 1'b1;
            else if (st.dAddr == adc_ctl_pkg::OFS_SPECIAL)
               next.trigSel = hwdata[adc_ctl_pkg::SPEC_TRIG_LSB +: 3];
         end
         else if (!st.dWrite && st.dValid)
         begin
            if (st.dAddr == adc_ctl_pkg::OFS_SELECT)
               rdByte = {st.refSel, st.align, st.inSel};
            else if (st.dAddr == adc_ctl_pkg::OFS_CTRL)
               // start bit shows the running conversion
               rdByte = {st.enable, st.active, st.autoTrig, st.flag, st.irqEn, st.divSel};
            else if (st.dAddr == adc_ctl_pkg::OFS_RES_LOW)
            begin
               rdByte = resultByte(st.result, st.align, 1'b0);
               // low byte read locks the pair
               next.lockLow = 1'b1;
            end
            else if (st.dAddr == adc_ctl_pkg::OFS_RES_HIGH)
            begin
               rdByte = resultByte(st.result, st.align, 1'b1);
               readHigh = 1'b1;
               next.lockLow = 1'b0;
            end
            else if (st.dAddr == adc_ctl_pkg::OFS_SPECIAL)
               rdByte = {st.trigSel, 5'h00};
         end
         if (!st.dWrite)
            next.rdata = {24'h000000, rdByte};
      end
      if (hsel && htrans[1] && hready)
      begin
         next.dataPhase = 1'b1;
         next.readyOut = 1'b0;
         next.dWrite = hwrite;
         next.dValid = (hsize == adc_ctl_pkg::SIZE_WORD) && (haddr[31:8] == 24'h000000);
         next.dAddr = haddr[7:0];
      end
      if (wrCtrl)
      begin
         if (hwdata[adc_ctl_pkg::CTRL_ENABLE] && !st.enable)
            next.firstPend = 1'b1;
         next.enable = hwdata[adc_ctl_pkg::CTRL_ENABLE];
         next.autoTrig = hwdata[adc_ctl_pkg::CTRL_AUTO];
         next.irqEn = hwdata[adc_ctl_pkg::CTRL_IRQEN];
         next.divSel = hwdata[adc_ctl_pkg::CTRL_DIV_LSB +: 3];
         // write one clears the flag, zero leaves it
         if (hwdata[adc_ctl_pkg::CTRL_FLAG])
            next.flag = 1'b0;
         // a written zero start bit is ignored
         if (hwdata[adc_ctl_pkg::CTRL_START] && hwdata[adc_ctl_pkg::CTRL_ENABLE])
            startWant = 1'b1;
         if (!hwdata[adc_ctl_pkg::CTRL_ENABLE])
         begin
            next.active = 1'b0;
            next.firstPend = 1'b0;
            next.firstNow = 1'b0;
         end
      end
      if (interruptTaken)
         next.flag = 1'b0;
      // a completion that arrives after a disable is dropped; one in the same cycle as the disable write still counts
      if (cv.done && st.enable)
      begin
         next.active = 1'b0;
         next.firstNow = 1'b0;
         // differential codes stored as two's complement
         if (!next.lockLow)
            next.result = st.chan.diff ? {~convData[9], convData[8:0]} : convData;
         // set wins over any clear in the same cycle
         next.flag = 1'b1;
         if (st.autoTrig && st.trigSel == adc_ctl_pkg::TRIG_FREE)
            startWant = 1'b1;
      end
      // source zero is tied low, so it never yields an edge
      trigVec = {triggerIn, 1'b0};
      trigLevel = trigVec[st.trigSel];
      next.trigPrev = trigLevel;
      if (st.autoTrig && trigLevel && !st.trigPrev)
         startWant = 1'b1;
      // selection latched only when a conversion starts
      if (startWant && next.enable && !next.active)
      begin
         next.active = 1'b1;
         next.startReq = 1'b1;
         next.firstNow = next.firstPend;
         next.firstPend = 1'b0;
         next.chan = decodeSel(next.inSel);
         next.chanRef = next.refSel;
      end
      next.irqReq = next.flag && next.irqEn && globalIrqEnable;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '0;
         st.readyOut <= 1'b1;
      end
      else if (clkEn)
         st <= next;
   end

   assign cv.enable = st.enable;
   assign cv.start  = st.startReq;
   assign cv.first  = st.firstNow;
   assign cv.divSel = st.divSel;

   assign hrdata    = st.rdata;
   assign hreadyout = st.readyOut;
   assign hresp     = st.respErr;
   assign irqReq    = st.irqReq;
   assign convBusy  = st.active;
   assign convInit  = st.firstNow;
   assign chanPos   = st.chan.pos;
   assign chanNeg   = st.chan.neg;
   assign chanGain  = st.chan.gain;
   assign chanDiff  = st.chan.diff;
   assign chanRef   = st.chanRef;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   chk_irq_gating: assert property (irqReq |-> (st.flag && st.irqEn))
      else $error("interrupt request without flag and enable");
   chk_busy_enabled: assert property (st.active |-> st.enable)
      else $error("busy while switched off");
   chk_abort_disable: assert property ((clkEn && wrCtrl && !hwdata[7])
      |=> (!st.active && !st.enable))
      else $error("disable did not abort");
   chk_flag_on_done: assert property ((clkEn && cv.done && st.enable) |=> st.flag)
      else $error("flag missing after completion");
   chk_ack_clears: assert property ((clkEn && interruptTaken && !(cv.done && st.enable))
      |=> !st.flag)
      else $error("flag survived vector taken");
   chk_lock_holds: assert property ((clkEn && st.lockLow && !readHigh) |=> $stable(st.result))
      else $error("result changed while locked");
   chk_select_held: assert property ((clkEn && st.active && !cv.done) |=> $stable(st.chan))
      else $error("routing changed mid conversion");
   chk_free_restart: assert property ((clkEn && cv.done && st.enable && st.autoTrig
      && st.trigSel == 3'h0 && !wrCtrl) |=> (st.startReq && st.active))
      else $error("free running did not restart");
   chk_align_right: assert property ((clkEn && st.dataPhase && !st.dWrite && st.dValid
      && st.dAddr == 8'h0c && !st.align) |=> hrdata[7:2] == 6'h00)
      else $error("right aligned high byte has stray bits");

   cov_first_done: cover property (st.firstNow && cv.done);
   cov_lock_block: cover property (st.lockLow && cv.done && st.enable);
   cov_free_run: cover property (cv.done && st.autoTrig && st.trigSel == 3'h0);
   cov_irq_raise: cover property ($rose(irqReq));

endmodule
`default_nettype wire

//--- logic/conv_if.sv
// link between the register side and the conversion timer
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
   logic       enable;
   logic       start;
   logic       first;
   logic [2:0] divSel;
   logic       done;

   modport ctrl (output enable, output start, output first, output divSel, input done);
   modport seq  (input enable, input start, input first, input divSel, output done);
endinterface
`default_nettype wire

//--- logic/conv_sequencer.sv
// prescaler and conversion cycle timer
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer #(
   parameter int PRE_W = 7
) (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic clkEn,
   conv_if.seq       cv
);

   typedef struct packed {
      adc_ctl_pkg::seq_phase_t phase;
      logic [PRE_W-1:0]        pre;
      logic [4:0]              cyc;
      logic                    done;
   } seq_state_t;

   seq_state_t st;
   seq_state_t next;
   logic       tick;

   if (PRE_W < 7)
   begin : g_check
      $error("PRE_W must hold a count of 127");
   end

   // terminal count of the prescaler for one divider code
   function automatic logic [PRE_W-1:0] preLimit(input logic [2:0] code);
      logic [7:0] lim;
      lim = 8'h01;
      if (code > adc_ctl_pkg::DIV_MIN_CODE)
         lim = 8'((9'h001 << code) - 9'h001);
      return PRE_W'(lim);
   endfunction

   always_comb
   begin
      next = st;
      next.done = 1'b0;
      tick = cv.enable && (st.pre == preLimit(cv.divSel));
      // counter idles at zero while off
      if (!cv.enable)
         next.pre = '0;
      else if (tick)
         next.pre = '0;
      else
         next.pre = st.pre + 1'b1;
      case (st.phase)
         adc_ctl_pkg::SEQ_IDLE:
            if (cv.start && cv.enable)
            begin
               next.phase = adc_ctl_pkg::SEQ_CONVERT;
               next.cyc = cv.first ? adc_ctl_pkg::FIRST_CYCLES : adc_ctl_pkg::NORMAL_CYCLES;
            end
         adc_ctl_pkg::SEQ_CONVERT:
            if (!cv.enable)
               next.phase = adc_ctl_pkg::SEQ_IDLE;
            else if (tick)
            begin
               if (st.cyc == 5'h01)
               begin
                  next.phase = adc_ctl_pkg::SEQ_IDLE;
                  next.done = 1'b1;
               end
               else
                  next.cyc = st.cyc - 5'h01;
            end
         default:
            next.phase = adc_ctl_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         st <= '0;
      else if (clkEn)
         st <= next;
   end

   assign cv.done = st.done;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   chk_prescaler_idle: assert property ((clkEn && !cv.enable) |=> st.pre == '0)
      else $error("prescaler not cleared while off");
   chk_first_length: assert property ((clkEn && st.phase == adc_ctl_pkg::SEQ_IDLE && cv.start
      && cv.enable) |=> st.cyc == ($past(cv.first) ? 5'h19 : 5'h0d))
      else $error("wrong conversion length loaded");
   chk_abort_quiet: assert property ((clkEn && !cv.enable && st.phase == adc_ctl_pkg::SEQ_CONVERT)
      |=> (st.phase == adc_ctl_pkg::SEQ_IDLE && !st.done))
      else $error("aborted conversion still completed");
   chk_divide_rate: assert property ((clkEn && tick) |=> !tick)
      else $error("converter clock faster than half rate");

endmodule
`default_nettype wire
